// file: core/fpc_top.sv
// fractional pll control: reference mux, divider setup, lock, phase steps
`timescale 1ns/10ps
`default_nettype none
// What this block does
// RULE1: select code top bit zero picks local inputs
// RULE2: pin select off: primary field steers mux
// RULE3: pin select on: pin low primary, high alternate
// RULE4: a field picks which pin steers mux
// RULE5: each input prescaled by 1, 2, 4, 8
// RULE6: software keeps common detector frequency in range
// RULE7: invert bit flips input polarity before mux
// RULE8: select code 11x takes digital loop clock
// RULE9: loop runs only while enable is one
// RULE10: ratio is main plus scaled remainder fraction
// RULE11: main divider nine or seven integer bits
// RULE12: software uses 24, never under 12, fraction bits
// RULE13: two vco dividers take their own ratios
// RULE14: software toggles enable to load divider settings
// RULE15: two status bits show live lock state
// RULE16: each step moves phase one eighth vco
// RULE17: step sources: register bit or any pin
// RULE18: step on both edges of chosen source
// RULE19: each step reaches both vco dividers
// RULE20: pin controls synchronised before edge detection
module fpc_top import fpc_pkg::*; (
    input wire logic clk, // 50 MHz system clock
    input wire logic rstn, // async reset, active low
    input wire logic input_clock_one, // input clock 1 level
    input wire logic input_clock_two, // input clock 2 level
    input wire logic input_clock_three, // input clock 3 level
    input wire logic osc_input_pin, // oscillator pin clock level
    input wire logic xtal_clk, // crystal driver output level
    input wire logic dpll_clk, // digital loop output clock level
    input wire logic [FPC_GPIO_N-1:0] gpio_in, // general-purpose pins
    input wire logic [2:0] ref_select_primary, // primary reference code
    input wire logic [2:0] ref_select_alternate, // alternate reference code
    input wire logic pin_select_enable, // pin steers reference mux
    input wire logic [1:0] select_pin_choice, // pin index steering mux
    input wire logic [1:0] prescale_one, // input 1 prescaler code
    input wire logic [1:0] prescale_two, // input 2 prescaler code
    input wire logic [1:0] prescale_three, // input 3 prescaler code
    input wire logic [FPC_NUM_IN-1:0] input_invert, // per-input inversion
    input wire logic analog_loop_enable, // loop enable
    input wire logic [FPC_FB_MAIN_W-1:0] fb_div_main, // fixed-point main divider
    input wire logic [FPC_FB_REM_W-1:0] fb_div_remainder, // remainder numerator
    input wire logic [FPC_FB_DEN_W-1:0] fb_div_denominator, // remainder denominator
    input wire logic [FPC_FB_BP_W-1:0] fb_binary_point, // binary point field
    input wire logic [FPC_HSDIV_W-1:0] vco_divider_one, // first vco divider ratio
    input wire logic [FPC_HSDIV_W-1:0] vco_divider_two, // second vco divider ratio
    input wire logic [2:0] phase_dec_source, // decrement source code
    input wire logic [2:0] phase_inc_source, // increment source code
    input wire logic phase_dec_bit, // decrement control bit
    input wire logic phase_inc_bit, // increment control bit
    input wire logic analog_lock_raw, // raw lock from analog loop
    output logic pll_ref_out, // selected reference to detector
    output fpc_mode_t loop_mode, // current operating mode
    output logic loop_run, // analog loop running
    output logic [FPC_FB_INT_SA-1:0] fb_integer, // integer part of ratio
    output logic [FPC_FB_FRAC_MAX-1:0] fb_fraction, // 33-bit fraction of ratio
    output logic [FPC_FB_REM_W-1:0] fb_rem_out, // remainder for modulator
    output logic [FPC_FB_DEN_W-1:0] fb_den_out, // denominator for modulator
    output logic [FPC_FB_BP_W-1:0] fb_lsb_exp, // remainder lsb weight exponent
    output logic [FPC_HSDIV_W-1:0] hs_div_one_ratio, // applied divider 1 ratio
    output logic [FPC_HSDIV_W-1:0] hs_div_two_ratio, // applied divider 2 ratio
    output logic lock_flag_a, // lock status bit a
    output logic lock_flag_b, // lock status bit b
    output logic hs_step_inc, // one-cycle eighth step forward
    output logic hs_step_dec, // one-cycle eighth step backward
    output logic [FPC_PH_POS_W-1:0] phase_position // net steps in eighths
);
    logic [FPC_GPIO_N-1:0] gpio_sync;
    logic lock_sync;
    logic [FPC_NUM_IN-1:0] in_raw;
    logic [FPC_NUM_IN-1:0] in_div;
    logic [1:0] pre_code [FPC_NUM_IN];
    logic [2:0] sel_code;
    logic ref_next;
    fpc_mode_t mode_next;
    logic en_reg;
    logic inc_src;
    logic dec_src;
    logic inc_prev_reg;
    logic dec_prev_reg;
    logic inc_edge;
    logic dec_edge;
    logic [FPC_FB_BP_W-1:0] bp_clamp;
    logic [FPC_FB_WIDE_W-1:0] fb_wide;
    logic [FPC_FB_INT_SA-1:0] int_next;

    // pin levels pass two flops before any decision is made
    fpc_sync #(.W(FPC_GPIO_N)) u_gpio_sync ( // RULE20
        .clk(clk),
        .rstn(rstn),
        .d(gpio_in),
        .q(gpio_sync)
    );

    // lock comes from the analog domain, so it is resynchronised too
    fpc_sync #(.W(1)) u_lock_sync (
        .clk(clk),
        .rstn(rstn),
        .d(analog_lock_raw),
        .q(lock_sync)
    );

    // gather the three inputs for the per-input prescalers
    assign in_raw = {input_clock_three, input_clock_two, input_clock_one};
    assign pre_code[0] = prescale_one;
    assign pre_code[1] = prescale_two;
    assign pre_code[2] = prescale_three;

    // one inverter and prescaler per input clock
    generate
        for (genvar i = 0; i < FPC_NUM_IN; i++) begin : g_in
            fpc_prescale u_pre ( // RULE5 RULE7
                .clk(clk),
                .rstn(rstn),
                .clk_in(in_raw[i]),
                .invert(input_invert[i]),
                .ratio(pre_code[i]),
                .clk_out(in_div[i])
            );
        end
    endgenerate

    // the chosen pin picks between the two select fields
    always_comb begin
        if (pin_select_enable) begin
            if (gpio_sync[select_pin_choice]) begin // RULE3 RULE4
                sel_code = ref_select_alternate;
            end else begin
                sel_code = ref_select_primary;
            end
        end else begin
            sel_code = ref_select_primary; // RULE2
        end
    end

    // decode the select code into a mode and a reference level
    always_comb begin
        ref_next = 1'b0;
        mode_next = FPC_MODE_INVALID;
        if (!analog_loop_enable) begin
            mode_next = FPC_MODE_OFF; // RULE9
        end else if (sel_code[2] == 1'b0) begin
            mode_next = FPC_MODE_STANDALONE; // RULE1
            unique case (sel_code[1:0])
                FPC_REF_IN1[1:0]: ref_next = in_div[0];
                FPC_REF_IN2[1:0]: ref_next = in_div[1];
                FPC_REF_IN3[1:0]: ref_next = in_div[2];
                FPC_REF_OSC[1:0]: ref_next = osc_input_pin;
            endcase
        end else if (sel_code[2:1] == FPC_CASC_TOP) begin
            mode_next = FPC_MODE_CASCADED; // RULE8
            ref_next = dpll_clk;
        end else if (sel_code == FPC_REF_XTAL) begin
            mode_next = FPC_MODE_STANDALONE; // RULE1
            ref_next = xtal_clk;
        end
        // code 101 selects nothing: reference held low, mode flagged
    end

    // reference and mode outputs, held quiet while disabled
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pll_ref_out <= 1'b0;
            loop_mode <= FPC_MODE_OFF;
        end else begin
            pll_ref_out <= ref_next; // RULE9
            loop_mode <= mode_next;
        end
    end

    // enable history; a rising enable loads new divider settings
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            en_reg <= 1'b0;
            loop_run <= 1'b0;
        end else begin
            en_reg <= analog_loop_enable;
            loop_run <= analog_loop_enable; // RULE9
        end
    end

    // binary point above 33 would shift past the fraction, so clamp it
    assign bp_clamp = (fb_binary_point > FPC_FB_BP_MAX) ? FPC_FB_BP_MAX : fb_binary_point;

    // align main divider so its fraction sits in a 33-bit field
    assign fb_wide = {{FPC_FB_FRAC_MAX{1'b0}}, fb_div_main} << bp_clamp; // RULE10 RULE11

    // cascaded mode keeps only seven integer bits
    always_comb begin
        int_next = fb_wide[FPC_FB_FRAC_MAX +: FPC_FB_INT_SA];
        if (mode_next == FPC_MODE_CASCADED) begin
            int_next[FPC_FB_INT_SA-1:FPC_FB_INT_CASC] = '0; // RULE11
        end
    end

    // divider settings are taken only on the 0 to 1 enable edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fb_integer <= '0;
            fb_fraction <= '0;
            fb_rem_out <= '0;
            fb_den_out <= '0;
            fb_lsb_exp <= FPC_FB_BP_MAX - FPC_FB_BP_RST;
        end else if (analog_loop_enable && !en_reg) begin // RULE14
            fb_integer <= int_next;
            fb_fraction <= fb_wide[FPC_FB_FRAC_MAX-1:0];
            fb_rem_out <= fb_div_remainder; // RULE10
            fb_den_out <= fb_div_denominator;
            fb_lsb_exp <= FPC_FB_BP_MAX - bp_clamp; // RULE10
        end
    end

    // the two vco dividers follow their own fields independently
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hs_div_one_ratio <= FPC_HSDIV_RST;
            hs_div_two_ratio <= FPC_HSDIV_RST;
        end else begin
            hs_div_one_ratio <= vco_divider_one; // RULE13
            hs_div_two_ratio <= vco_divider_two; // RULE13
        end
    end

    // both status bits track live lock; no lock claimed when disabled
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lock_flag_a <= 1'b0;
            lock_flag_b <= 1'b0;
        end else begin
            lock_flag_a <= lock_sync & analog_loop_enable; // RULE15
            lock_flag_b <= lock_sync & analog_loop_enable; // RULE15
        end
    end

    // pick each phase control from its bit or a synchronised pin
    always_comb begin
        inc_src = 1'b0;
        dec_src = 1'b0;
        if (phase_inc_source == FPC_PH_SRC_BIT) begin
            inc_src = phase_inc_bit; // RULE17
        end else if (phase_inc_source <= FPC_PH_SRC_GPIO_LAST) begin
            inc_src = gpio_sync[2'(phase_inc_source - FPC_PH_SRC_GPIO0)]; // RULE17 RULE20
        end
        if (phase_dec_source == FPC_PH_SRC_BIT) begin
            dec_src = phase_dec_bit; // RULE17
        end else if (phase_dec_source <= FPC_PH_SRC_GPIO_LAST) begin
            dec_src = gpio_sync[2'(phase_dec_source - FPC_PH_SRC_GPIO0)]; // RULE17 RULE20
        end
    end

    // remember the previous control levels for edge detection
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            inc_prev_reg <= 1'b0;
            dec_prev_reg <= 1'b0;
        end else begin
            inc_prev_reg <= inc_src;
            dec_prev_reg <= dec_src;
        end
    end

    // any change of level, rising or falling, is one step
    assign inc_edge = (inc_src ^ inc_prev_reg) & analog_loop_enable; // RULE18
    assign dec_edge = (dec_src ^ dec_prev_reg) & analog_loop_enable; // RULE18

    // simultaneous inc and dec cancel rather than fight
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hs_step_inc <= 1'b0;
            hs_step_dec <= 1'b0;
        end else begin
            hs_step_inc <= inc_edge & ~dec_edge; // RULE16 RULE19
            hs_step_dec <= dec_edge & ~inc_edge; // RULE16 RULE19
        end
    end

    // net phase offset in eighths of a vco period, wraps silently
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_position <= '0;
        end else if (inc_edge && !dec_edge) begin
            phase_position <= phase_position + 16'h0001; // RULE16
        end else if (dec_edge && !inc_edge) begin
            phase_position <= phase_position - 16'h0001; // RULE16
        end
    end
endmodule // fpc_top
`default_nettype wire

// file: core/fpc_pkg.sv
// constants and types shared by the fractional pll control block
package fpc_pkg;
    // reference select codes; top bit low means stand-alone operation
    localparam int FPC_SEL_W = 3;
    localparam logic [2:0] FPC_REF_IN1 = 3'h0;
    localparam logic [2:0] FPC_REF_IN2 = 3'h1;
    localparam logic [2:0] FPC_REF_IN3 = 3'h2;
    localparam logic [2:0] FPC_REF_OSC = 3'h3;
    localparam logic [2:0] FPC_REF_XTAL = 3'h4;
    localparam logic [1:0] FPC_CASC_TOP = 2'h3;
    // input prescaler codes
    localparam logic [1:0] FPC_PRE_DIV1 = 2'h0;
    localparam logic [1:0] FPC_PRE_DIV2 = 2'h1;
    localparam logic [1:0] FPC_PRE_DIV4 = 2'h2;
    localparam logic [1:0] FPC_PRE_DIV8 = 2'h3;
    localparam int FPC_NUM_IN = 3;
    // general-purpose pins and phase step sources
    localparam int FPC_GPIO_N = 4;
    localparam logic [2:0] FPC_PH_SRC_BIT = 3'h0;
    localparam logic [2:0] FPC_PH_SRC_GPIO0 = 3'h1;
    localparam logic [2:0] FPC_PH_SRC_GPIO_LAST = 3'h4;
    localparam int FPC_PH_POS_W = 16;
    // feedback divider fixed-point layout
    localparam int FPC_FB_INT_SA = 9;
    localparam int FPC_FB_INT_CASC = 7;
    localparam int FPC_FB_FRAC_MAX = 33;
    localparam int FPC_FB_MAIN_W = FPC_FB_INT_SA + FPC_FB_FRAC_MAX;
    localparam int FPC_FB_WIDE_W = FPC_FB_MAIN_W + FPC_FB_FRAC_MAX;
    localparam int FPC_FB_REM_W = 32;
    localparam int FPC_FB_DEN_W = 32;
    localparam int FPC_FB_BP_W = 6;
    localparam logic [5:0] FPC_FB_BP_MAX = 6'h21;
    localparam logic [5:0] FPC_FB_BP_RST = 6'h09;
    localparam int FPC_HSDIV_W = 4;
    localparam logic [3:0] FPC_HSDIV_RST = 4'h6;
    // operating mode of the analog loop
    typedef enum logic [1:0] {
        FPC_MODE_OFF,
        FPC_MODE_STANDALONE,
        FPC_MODE_CASCADED,
        FPC_MODE_INVALID
    } fpc_mode_t;
endpackage

// file: core/fpc_sync.sv
// two-stage synchroniser for a group of pin levels
`timescale 1ns/10ps
`default_nettype none
module fpc_sync import fpc_pkg::*; #(
    parameter int W = 1
) (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic [W-1:0] d, // asynchronous levels
    output logic [W-1:0] q // synchronised levels
);
    logic [W-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // fpc_sync
`default_nettype wire

// file: core/fpc_prescale.sv
// per-input polarity inversion and divide by 1, 2, 4 or 8
`timescale 1ns/10ps
`default_nettype none
module fpc_prescale import fpc_pkg::*; (
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic clk_in, // sampled input clock level
    input wire logic invert, // invert polarity first
    input wire logic [1:0] ratio, // prescaler code
    output logic clk_out // divided clock level
);
    logic pol_reg;
    logic [2:0] cnt_reg;
    logic pol_next;

    // inversion happens ahead of the divider and the mux
    assign pol_next = clk_in ^ invert; // RULE7

    // count rising edges; counter bits are the divided clocks
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pol_reg <= 1'b0;
            cnt_reg <= 3'h0;
        end else begin
            pol_reg <= pol_next;
            if (pol_next && !pol_reg) begin
                cnt_reg <= cnt_reg + 3'h1;
            end
        end
    end

    // select the tap for the chosen ratio
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            clk_out <= 1'b0;
        end else begin
            unique case (ratio) // RULE5
                FPC_PRE_DIV1: clk_out <= pol_next;
                FPC_PRE_DIV2: clk_out <= cnt_reg[0];
                FPC_PRE_DIV4: clk_out <= cnt_reg[1];
                FPC_PRE_DIV8: clk_out <= cnt_reg[2];
            endcase
        end
    end
endmodule // fpc_prescale
`default_nettype wire

// file: verif/fpc_top_sva.sv
// assertion checker for the fractional pll control top
`timescale 1ns/10ps
`default_nettype none
module fpc_top_sva import fpc_pkg::*; (
    input wire logic clk, // clock
    input wire logic rstn, // reset, low
    input wire logic osc_input_pin, // osc level
    input wire logic dpll_clk, // loop clock
    input wire logic pin_select_enable, // pin steers
    input wire logic [2:0] ref_select_primary, // ref code
    input wire logic analog_loop_enable, // enable
    input wire logic analog_lock_raw, // raw lock
    input wire logic [FPC_FB_REM_W-1:0] fb_div_remainder, // remainder
    input wire logic [FPC_FB_BP_W-1:0] fb_binary_point, // point
    input wire logic [FPC_HSDIV_W-1:0] vco_divider_one, // ratio
    input wire logic [2:0] phase_inc_source, // inc source
    input wire logic [2:0] phase_dec_source, // dec source
    input wire logic phase_inc_bit, // inc bit
    input wire logic pll_ref_out, // chosen ref
    input wire fpc_mode_t loop_mode, // mode
    input wire logic loop_run, // running
    input wire logic [FPC_FB_INT_SA-1:0] fb_integer, // integer
    input wire logic [FPC_FB_REM_W-1:0] fb_rem_out, // remainder
    input wire logic [FPC_FB_BP_W-1:0] fb_lsb_exp, // lsb weight
    input wire logic [FPC_HSDIV_W-1:0] hs_div_one_ratio, // applied
    input wire logic lock_flag_a, // lock a
    input wire logic lock_flag_b, // lock b
    input wire logic hs_step_inc, // step up
    input wire logic hs_step_dec, // step down
    input wire logic [FPC_PH_POS_W-1:0] phase_position // net steps
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // lock status and loop enable
    a_lock_pair: assert property (lock_flag_a == lock_flag_b)
        else $error("lock flags differ");
    a_lock_seen: assert property ((analog_loop_enable && analog_lock_raw)[*4] |-> lock_flag_a)
        else $error("lock not reported");
    // two cycles low leaves room for the registered gating
    a_off_quiet: assert property (!analog_loop_enable[*2] |=> !loop_run &&
        loop_mode == FPC_MODE_OFF && !lock_flag_a && !pll_ref_out) else $error("loop not off");
    // reference mux
    a_ref_osc: assert property ((!pin_select_enable && analog_loop_enable &&
        ref_select_primary == FPC_REF_OSC)[*2] |=> pll_ref_out == $past(osc_input_pin))
        else $error("osc not followed");
    a_ref_casc: assert property ((!pin_select_enable && analog_loop_enable &&
        ref_select_primary[2:1] == FPC_CASC_TOP)[*2] |=> loop_mode == FPC_MODE_CASCADED &&
        pll_ref_out == $past(dpll_clk)) else $error("cascade ref wrong");
    // feedback divider fields only move on an enable rise; vco ratio follows its field
    a_fb_load: assert property ($rose(analog_loop_enable) && fb_binary_point <= FPC_FB_BP_MAX
        |=> fb_rem_out == $past(fb_div_remainder) &&
        fb_lsb_exp == FPC_FB_BP_MAX - $past(fb_binary_point)) else $error("divider not loaded");
    a_fb_hold: assert property (analog_loop_enable && $past(analog_loop_enable) && $past(rstn)
        |=> $stable(fb_rem_out) && $stable(fb_integer)) else $error("divider moved");
    a_ratio_copy: assert property ($stable(vco_divider_one)[*3]
        |-> hs_div_one_ratio == vco_divider_one) else $error("ratio not applied");
    // phase steps
    a_step_bit: assert property (phase_inc_source == FPC_PH_SRC_BIT &&
        phase_dec_source > FPC_PH_SRC_GPIO_LAST && analog_loop_enable && $past(rstn) &&
        $changed(phase_inc_bit) |-> ##[1:2] hs_step_inc) else $error("step missed");
    a_step_pos: assert property (hs_step_inc != hs_step_dec |-> phase_position ==
        $past(phase_position) + (hs_step_inc ? 16'h0001 : 16'hffff)) else $error("bad position");
    c_lock: cover property ($rose(lock_flag_a));
    c_dec: cover property (hs_step_dec);
    c_casc: cover property (loop_mode == FPC_MODE_CASCADED);
endmodule // fpc_top_sva
bind fpc_top fpc_top_sva u_sva (.*);
`default_nettype wire

// file: verif/fpc_far_model.sv
// far-side model: reference clock levels and analog lock
`timescale 1ns/10ps
`default_nettype none
module fpc_far_model (
    input wire logic clk, // system clock
    input wire logic loop_on, // loop enable
    input wire logic [3:0] lock_wait, // lock delay, 0 prompt
    output logic [5:0] ref_lv, // dpll, xtal, osc, in3, in2, in1
    output logic lock_raw // analog lock level
);
    logic [7:0] tick = 8'h00;
    logic [4:0] held = 5'h00;
    // distinct rates per reference so a wrong pick shows
    always_ff @(posedge clk) begin
        tick <= tick + 8'h01;
    end
    assign ref_lv = {tick[3] ^ tick[1], tick[4], tick[0], tick[3], tick[2], tick[1]};
    // lock only reacquired after a fresh enable, never held through off
    always_ff @(posedge clk) begin
        held <= !loop_on ? 5'h00 : (held == 5'h1f) ? held : held + 5'h01;
    end
    assign lock_raw = loop_on && (held > {1'b0, lock_wait});
endmodule // fpc_far_model
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the fractional pll control top
`timescale 1ns/10ps
`default_nettype none
module tb_top import fpc_pkg::*; ;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic input_clock_one, input_clock_two, input_clock_three, osc_input_pin, xtal_clk, dpll_clk;
    logic [3:0] gpio_in = 4'h0;
    logic [2:0] ref_select_primary = 3'h0, ref_select_alternate = 3'h0, input_invert = 3'h0;
    logic pin_select_enable = 1'b0, analog_loop_enable = 1'b0;
    logic [1:0] select_pin_choice = 2'h0, prescale_one = 2'h0, prescale_two = 2'h0;
    logic [1:0] prescale_three = 2'h0;
    logic [41:0] fb_div_main = 42'h0;
    logic [31:0] fb_div_remainder = 32'h0, fb_div_denominator = 32'h1;
    logic [5:0] fb_binary_point = FPC_FB_BP_RST;
    logic [3:0] vco_divider_one = 4'h6, vco_divider_two = 4'h6, lock_wait = 4'h0;
    logic [2:0] phase_dec_source = 3'h7, phase_inc_source = 3'h7;
    logic phase_dec_bit = 1'b0, phase_inc_bit = 1'b0, analog_lock_raw;
    logic pll_ref_out, loop_run, lock_flag_a, lock_flag_b, hs_step_inc, hs_step_dec;
    fpc_mode_t loop_mode;
    logic [8:0] fb_integer;
    logic [32:0] fb_fraction;
    logic [31:0] fb_rem_out, fb_den_out;
    logic [5:0] fb_lsb_exp;
    logic [3:0] hs_div_one_ratio, hs_div_two_ratio;
    logic [15:0] phase_position, pos_exp;
    logic [5:0] ref_lv, ref_q, ref_q2;
    logic [74:0] wide;
    int mismatches = 0, n_checks = 0, cnt;
    // clock, pre-edge copy of references, and the two instances
    always #10 clk = ~clk;
    always @(posedge clk) {ref_q2, ref_q} <= {ref_q, ref_lv};
    assign {dpll_clk, xtal_clk, osc_input_pin, input_clock_three, input_clock_two,
        input_clock_one} = ref_lv;
    fpc_top u_dut (.*);
    fpc_far_model u_far (.clk(clk), .loop_on(analog_loop_enable), .lock_wait(lock_wait),
        .ref_lv(ref_lv), .lock_raw(analog_lock_raw));
    task automatic check(input logic [74:0] seen, input logic [74:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    // drives land just after the edge, away from sampling
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // direct levels show one edge later; prescaled inputs pass one more flop
    task automatic follow(input logic [2:0] code, input int n);
        logic e;
        repeat (n) begin
            step(1);
            e = (code < 3'h3) ? ref_q2[code] ^ input_invert[code] : (code == 3'h5) ? 1'b0 :
                ref_q[(code > 3'h5) ? 3'h5 : code];
            check(pll_ref_out, e);
        end
    endtask
    // window is a whole number of every divided period
    task automatic rises(output int c);
        logic prev;
        c = 0;
        prev = pll_ref_out;
        repeat (128) begin
            step(1);
            c += int'(pll_ref_out && !prev);
            prev = pll_ref_out;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        check({hs_div_one_ratio, hs_div_two_ratio, fb_lsb_exp}, {4'h6, 4'h6, 6'h18});
        check({loop_mode, loop_run, lock_flag_a, phase_position}, 20'h0);
        #1 rstn = 1'b1;
        step(3);
        check({loop_mode, pll_ref_out}, {FPC_MODE_OFF, 1'b0});
        for (int i = 0; i < 4; i++) begin
            fb_binary_point = (i == 0) ? 6'h09 : (i == 1) ? 6'h0c : (i == 2) ? 6'h21 : 6'h28;
            fb_div_main = 42'h3ff01234567 - 42'(i);
            fb_div_remainder = 32'h12340000 + 32'(i);
            fb_div_denominator = 32'h000000ed;
            ref_select_primary = (i == 3) ? 3'h6 : 3'h3;
            lock_wait = 4'(i * 4);
            step(2);
            analog_loop_enable = 1'b1;
            step(3);
            wide = {33'h0, fb_div_main} << ((i == 3) ? 6'h21 : fb_binary_point);
            check(fb_integer, wide[41:33] & ((i == 3) ? 9'h07f : 9'h1ff));
            check({fb_fraction, fb_den_out}, {wide[32:0], fb_div_denominator});
            check(fb_lsb_exp, (i == 3) ? 6'h00 : 6'h21 - fb_binary_point);
            fb_div_main = 42'h0;
            fb_div_remainder = 32'h0;
            step(16);
            check({fb_fraction, lock_flag_a, lock_flag_b}, {wide[32:0], 2'h3});
            analog_loop_enable = 1'b0;
            step(4);
            check({lock_flag_a, lock_flag_b}, 2'h0);
        end
        vco_divider_one = 4'h9;
        vco_divider_two = 4'hb;
        analog_loop_enable = 1'b1;
        for (int c = 0; c < 8; c++) begin
            ref_select_primary = 3'(c);
            input_invert = (c % 2 == 1) ? 3'h7 : 3'h0;
            step(3);
            check(loop_mode, (c == 5) ? FPC_MODE_INVALID : (c > 5) ? FPC_MODE_CASCADED :
                FPC_MODE_STANDALONE);
            follow(ref_select_primary, 6);
        end
        check({hs_div_one_ratio, hs_div_two_ratio}, 8'h9b);
        input_invert = 3'h0;
        for (int c = 0; c < 3; c++) begin
            ref_select_primary = 3'(c);
            for (int p = 0; p < 4; p++) begin
                {prescale_three, prescale_two, prescale_one} = {3{2'(p)}};
                step(40);
                rises(cnt);
                check(cnt, (32 >> c) >> p);
            end
        end
        // pin steering, each pin in turn, others held opposite
        pin_select_enable = 1'b1;
        ref_select_primary = FPC_REF_OSC;
        ref_select_alternate = FPC_REF_XTAL;
        for (int k = 0; k < 4; k++) begin
            select_pin_choice = 2'(k);
            gpio_in = ~(4'h1 << k);
            step(4);
            follow(FPC_REF_OSC, 4);
            gpio_in = 4'h1 << k;
            step(4);
            follow(FPC_REF_XTAL, 4);
        end
        // phase steps: slow then back-to-back toggles of the bit
        pin_select_enable = 1'b0;
        gpio_in = 4'h0;
        phase_inc_source = FPC_PH_SRC_BIT;
        step(4);
        pos_exp = phase_position + 16'h6;
        for (int t = 0; t < 6; t++) begin
            phase_inc_bit = ~phase_inc_bit;
            step((t < 2) ? 3 : 1);
        end
        step(4);
        check(phase_position, pos_exp);
        phase_inc_source = 3'h7;
        for (int k = 0; k < 5; k++) begin
            phase_dec_source = 3'(k);
            step(2);
            {gpio_in, phase_dec_bit} = 5'h01 << k;
            step(5);
            {gpio_in, phase_dec_bit} = 5'h00;
            step(5);
        end
        pos_exp = pos_exp - 16'ha;
        check(phase_position, pos_exp);
        analog_loop_enable = 1'b0;
        phase_dec_source = FPC_PH_SRC_BIT;
        step(2);
        phase_dec_bit = 1'b1;
        step(6);
        check(phase_position, pos_exp);
        tally_and_finish();
    end
    // watchdog at several times the expected run length
    initial begin
        #400000;
        mismatches++;
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
